// >>> rtl/p4pfs_defines.svh
// Constants for the port 4 pin function select block
`ifndef P4PFS_DEFINES_SVH
`define P4PFS_DEFINES_SVH
`define P4PFS_RXSEL_SCL 2'h3
`define P4PFS_SMD_I2C 3'h2
`define P4PFS_ADC_TRIGGER_SOURCE_SELECT_EXT 2'h3
`define P4PFS_TIMER_B_MODE_FIELD_PULSE 2'h1
`define P4PFS_TIMER_B_MODE_FIELD_ONESHOT 2'h2
`define P4PFS_TIMER_B_MODE_FIELD_WAIT 2'h3
`define P4PFS_RST_LOW 1'h0
`endif

// >>> rtl/p4pfs_osc_ctrl.sv
// Oscillator buffer and feedback resistor decode for the two oscillator pins
`timescale 1ns/1ps
`default_nettype none
module p4pfs_osc_ctrl
   import p4pfs_pkg::*;
(
   // Clock bits
   input wire logic subClockSourceBit,
   input wire logic subOscStopBit,
   input wire logic subOscPinSelect,
   input wire logic mainOscStopBit,
   input wire logic allClockStopBit,
   input wire logic mainOscFeedbackOffBit,
   input wire logic subOscFeedbackOffBit,
   input wire logic mainOscPinEnable,
   // Decoded controls
   output logic mainBufOn,
   output logic mainFbOn,
   output logic subBufOn,
   output logic subFbOn,
   output p4pfs_oscfn_e oscFn
);
   // Purely combinational; the top registers all of it
   always_comb begin
      mainBufOn = 1'b0;
      mainFbOn = 1'b0;
      subBufOn = 1'b0;
      subFbOn = 1'b0;
      oscFn = P4PFS_OSC_PORT;
      if (allClockStopBit) begin
         // Stop mode wins over every other bit
         oscFn = P4PFS_OSC_STOP; // RULE11
      end else if (mainOscPinEnable && !subClockSourceBit) begin
         oscFn = P4PFS_OSC_MAIN;
         mainBufOn = !mainOscStopBit; // RULE5 RULE7
         mainFbOn = !mainOscFeedbackOffBit; // RULE6
      end else if (mainOscPinEnable && subOscPinSelect) begin
         oscFn = P4PFS_OSC_SUB;
         subBufOn = !subOscStopBit; // RULE8 RULE10
         subFbOn = !subOscFeedbackOffBit; // RULE9
      end else if (!subOscPinSelect && !mainOscPinEnable) begin
         // Plain port, all analog parts off
         oscFn = P4PFS_OSC_PORT; // RULE15
      end else begin
         // Undefined mixes are left as port with circuits off
         oscFn = P4PFS_OSC_PORT;
      end
   end
endmodule
`default_nettype wire

// >>> rtl/p4pfs_pkg.sv
// Types shared by the port 4 pin function select block
package p4pfs_pkg;
   // Function of the shared receive pin
   typedef enum logic [2:0] {
      P4PFS_RX_IN   = 3'h0,
      P4PFS_RX_OUT  = 3'h1,
      P4PFS_RX_UART = 3'h3,
      P4PFS_RX_SCL  = 3'h2
   } p4pfs_rxfn_e;
   // Function of the oscillator pins
   typedef enum logic [2:0] {
      P4PFS_OSC_PORT = 3'h0,
      P4PFS_OSC_MAIN = 3'h1,
      P4PFS_OSC_SUB  = 3'h3,
      P4PFS_OSC_STOP = 3'h2
   } p4pfs_oscfn_e;
   // Timer B pin function
   typedef enum logic [2:0] {
      P4PFS_TB_OFF     = 3'h0,
      P4PFS_TB_PULSE   = 3'h1,
      P4PFS_TB_PROG    = 3'h3,
      P4PFS_TB_ONESHOT = 3'h2,
      P4PFS_TB_WAIT    = 3'h6
   } p4pfs_tbfn_e;
endpackage

// >>> rtl/p4pfs_port4_pin_select.sv
// Pin function select for port 4 upper pins and the timer B output pin
// Overview of operation
// (RULE1) Receive pin is I2C clock when selected
// (RULE2) Pull-up enabled on inputs by pull-up bit
// (RULE3) High drive on outputs by drive bit
// (RULE4) I2C clock output open drain when set
// (RULE5) Main oscillator runs with buffer and resistor
// (RULE6) Main feedback resistor off by its bit
// (RULE7) Main stop bit turns buffer off
// (RULE8) Sub oscillator runs with buffer and resistor
// (RULE9) Sub feedback resistor off by its bit
// (RULE10) Sub stop bit turns buffer off
// (RULE11) Stop mode turns all oscillator circuits off
// (RULE12) Timer B mode 01: pulse or programmable
// (RULE13) Mode 10 one-shot, 11 wait one-shot
// (RULE14) Otherwise receive pin is general port
// (RULE15) Oscillator pins general ports when unselected; the code holds their output enables off in stop mode even when unselected
// (RULE16) Reference pin also reference input when enabled
`timescale 1ns/1ps
`default_nettype none
`include "p4pfs_defines.svh"
module p4pfs_port4_pin_select (
   // Clock and reset
   input wire logic sysClk,
   input wire logic arstN,
   // Port direction and electrical controls
   input wire logic p45DirectionBit,
   input wire logic p46DirectionBit,
   input wire logic p47DirectionBit,
   input wire logic p4HiPullupBit,
   input wire logic p4HiDriveBit,
   // Port output data from software
   input wire logic p45OutData,
   input wire logic p46OutData,
   input wire logic p47OutData,
   // Receive pin function bits
   input wire logic extInt0InputEnable,
   input wire logic [1:0] uart2RxPinSelect,
   input wire logic [2:0] uart2SerialModeSelect,
   input wire logic uart2I2cModeBit,
   input wire logic uart2OpendrainBit,
   input wire logic [1:0] adcTriggerSourceSelect,
   input wire logic uart2SclOut,
   // Reference pin bits
   input wire logic adcStandbyBit,
   input wire logic dac0Enable,
   input wire logic dac1Enable,
   // Clock bits
   input wire logic subClockSourceBit,
   input wire logic subOscStopBit,
   input wire logic subOscPinSelect,
   input wire logic mainOscStopBit,
   input wire logic allClockStopBit,
   input wire logic mainOscFeedbackOffBit,
   input wire logic subOscFeedbackOffBit,
   input wire logic mainOscPinEnable,
   // Timer B bits
   input wire logic [1:0] timerBModeField,
   input wire logic timerBOutputCtrl,
   input wire logic timerBWave,
   // Pin inputs
   input wire logic p45PinIn,
   // Pin side outputs
   output logic p45PinOut,
   output logic p45PinOe,
   output logic p46PinOut,
   output logic p46PinOe,
   output logic p47PinOut,
   output logic p47PinOe,
   output logic p4PullupEn,
   output logic p4HiDriveEn,
   // Peripheral side inputs
   output logic externalInterruptZero,
   output logic uart2ReceiveInput,
   output logic adcExternalTrigger,
   output logic vrefInputEn,
   // Oscillator circuit controls
   output logic mainOscBufOn,
   output logic mainOscFbOn,
   output logic subOscBufOn,
   output logic subOscFbOn,
   // Timer B pin
   output logic timerBOutputPin,
   output logic timerBPinOe,
   output p4pfs_pkg::p4pfs_tbfn_e timerBFunction
);
   import p4pfs_pkg::*;

   // Decoded functions
   p4pfs_rxfn_e rxFn;
   p4pfs_oscfn_e oscFn;
   p4pfs_tbfn_e tbFn;
   logic mainBufNxt, mainFbNxt, subBufNxt, subFbNxt;
   logic sclDrive;

   // Oscillator decode lives in its own module
   p4pfs_osc_ctrl uOsc (
      .subClockSourceBit(subClockSourceBit),
      .subOscStopBit(subOscStopBit),
      .subOscPinSelect(subOscPinSelect),
      .mainOscStopBit(mainOscStopBit),
      .allClockStopBit(allClockStopBit),
      .mainOscFeedbackOffBit(mainOscFeedbackOffBit),
      .subOscFeedbackOffBit(subOscFeedbackOffBit),
      .mainOscPinEnable(mainOscPinEnable),
      .mainBufOn(mainBufNxt),
      .mainFbOn(mainFbNxt),
      .subBufOn(subBufNxt),
      .subFbOn(subFbNxt),
      .oscFn(oscFn)
   );

   // Receive pin function decode
   always_comb begin
      if (uart2RxPinSelect != `P4PFS_RXSEL_SCL) begin
         rxFn = p45DirectionBit ? P4PFS_RX_OUT : P4PFS_RX_IN; // RULE14
      end else if (uart2SerialModeSelect == `P4PFS_SMD_I2C && uart2I2cModeBit) begin
         rxFn = P4PFS_RX_SCL; // RULE1
      end else begin
         rxFn = P4PFS_RX_UART;
      end
   end

   // Timer B function decode
   always_comb begin
      case (timerBModeField)
         `P4PFS_TIMER_B_MODE_FIELD_PULSE: tbFn = timerBOutputCtrl ? P4PFS_TB_PROG : P4PFS_TB_PULSE; // RULE12
         `P4PFS_TIMER_B_MODE_FIELD_ONESHOT: tbFn = timerBOutputCtrl ? P4PFS_TB_OFF : P4PFS_TB_ONESHOT; // RULE13
         `P4PFS_TIMER_B_MODE_FIELD_WAIT: tbFn = timerBOutputCtrl ? P4PFS_TB_OFF : P4PFS_TB_WAIT; // RULE13
         default: tbFn = P4PFS_TB_OFF;
      endcase
   end

   // I2C clock only pulls low when open drain is chosen
   assign sclDrive = uart2OpendrainBit ? !uart2SclOut : 1'b1;

   // Receive pin outputs and peripheral feeds
   always_ff @(posedge sysClk or negedge arstN) begin
      if (!arstN) begin
         p45PinOut <= `P4PFS_RST_LOW;
         p45PinOe <= `P4PFS_RST_LOW;
         externalInterruptZero <= `P4PFS_RST_LOW;
         uart2ReceiveInput <= `P4PFS_RST_LOW;
         adcExternalTrigger <= `P4PFS_RST_LOW;
      end else begin
         case (rxFn)
            P4PFS_RX_OUT: begin
               p45PinOut <= p45OutData;
               p45PinOe <= 1'b1;
            end
            P4PFS_RX_SCL: begin
               // Open drain drives only the low level
               p45PinOut <= uart2OpendrainBit ? 1'b0 : uart2SclOut; // RULE4
               p45PinOe <= sclDrive; // RULE4
            end
            default: begin
               p45PinOut <= 1'b0;
               p45PinOe <= 1'b0;
            end
         endcase
         // Interrupt and trigger taps only in port mode
         externalInterruptZero <= (rxFn == P4PFS_RX_IN) && extInt0InputEnable && p45PinIn; // RULE14
         adcExternalTrigger <= (rxFn == P4PFS_RX_IN) && extInt0InputEnable
            && (adcTriggerSourceSelect == `P4PFS_ADC_TRIGGER_SOURCE_SELECT_EXT) && p45PinIn; // RULE14
         uart2ReceiveInput <= (rxFn == P4PFS_RX_UART || rxFn == P4PFS_RX_SCL) && p45PinIn; // RULE1
      end
   end

   // Oscillator pins and circuit enables
   always_ff @(posedge sysClk or negedge arstN) begin
      if (!arstN) begin
         p46PinOut <= `P4PFS_RST_LOW;
         p46PinOe <= `P4PFS_RST_LOW;
         p47PinOut <= `P4PFS_RST_LOW;
         p47PinOe <= `P4PFS_RST_LOW;
         mainOscBufOn <= `P4PFS_RST_LOW;
         mainOscFbOn <= `P4PFS_RST_LOW;
         subOscBufOn <= `P4PFS_RST_LOW;
         subOscFbOn <= `P4PFS_RST_LOW;
      end else begin
         // Digital drive only while pins are plain ports
         p46PinOut <= p46OutData;
         p46PinOe <= (oscFn == P4PFS_OSC_PORT) && p46DirectionBit; // RULE15
         p47PinOut <= p47OutData;
         p47PinOe <= (oscFn == P4PFS_OSC_PORT) && p47DirectionBit; // RULE15
         mainOscBufOn <= mainBufNxt; // RULE5
         mainOscFbOn <= mainFbNxt; // RULE6
         subOscBufOn <= subBufNxt; // RULE8
         subOscFbOn <= subFbNxt; // RULE9
      end
   end

   // Electrical options and reference pin
   always_ff @(posedge sysClk or negedge arstN) begin
      if (!arstN) begin
         p4PullupEn <= `P4PFS_RST_LOW;
         p4HiDriveEn <= `P4PFS_RST_LOW;
         vrefInputEn <= `P4PFS_RST_LOW;
      end else begin
         p4PullupEn <= p4HiPullupBit; // RULE2
         p4HiDriveEn <= p4HiDriveBit; // RULE3
         vrefInputEn <= adcStandbyBit || dac0Enable || dac1Enable; // RULE16
      end
   end

   // Timer B pin
   always_ff @(posedge sysClk or negedge arstN) begin
      if (!arstN) begin
         timerBOutputPin <= `P4PFS_RST_LOW;
         timerBPinOe <= `P4PFS_RST_LOW;
         timerBFunction <= P4PFS_TB_OFF;
      end else begin
         timerBFunction <= tbFn; // RULE12
         timerBPinOe <= (tbFn != P4PFS_TB_OFF); // RULE13
         timerBOutputPin <= (tbFn != P4PFS_TB_OFF) && timerBWave;
      end
   end

   // Checks
   chk_scl_select: assert property (@(posedge sysClk) disable iff (!arstN)
      (uart2RxPinSelect == 2'h3 && uart2SerialModeSelect == 3'h2 && uart2I2cModeBit
       && !uart2OpendrainBit) |=> p45PinOe) // RULE1
      else $error("I2C clock pin not driven");
   chk_pullup_follow: assert property (@(posedge sysClk) disable iff (!arstN)
      p4HiPullupBit |=> p4PullupEn) // RULE2
      else $error("pull-up not enabled");
   chk_drive_follow: assert property (@(posedge sysClk) disable iff (!arstN)
      !p4HiDriveBit |=> !p4HiDriveEn) // RULE3
      else $error("high drive stuck");
   chk_od_nohigh: assert property (@(posedge sysClk) disable iff (!arstN)
      (rxFn == P4PFS_RX_SCL && uart2OpendrainBit) |=> !(p45PinOe && p45PinOut)) // RULE4
      else $error("open drain drove high");
   chk_main_run: assert property (@(posedge sysClk) disable iff (!arstN)
      (!subClockSourceBit && !mainOscStopBit && !mainOscFeedbackOffBit && !allClockStopBit
       && mainOscPinEnable) |=> (mainOscBufOn && mainOscFbOn)) // RULE5
      else $error("main oscillator not running");
   chk_sub_run: assert property (@(posedge sysClk) disable iff (!arstN)
      (subClockSourceBit && subOscPinSelect && mainOscPinEnable && !subOscStopBit
       && !subOscFeedbackOffBit && !allClockStopBit) |=> (subOscBufOn && subOscFbOn)) // RULE8
      else $error("sub oscillator not running");
   chk_stop_all: assert property (@(posedge sysClk) disable iff (!arstN)
      allClockStopBit |=> !(mainOscBufOn || mainOscFbOn || subOscBufOn || subOscFbOn)) // RULE11
      else $error("circuit on in stop mode");
   chk_tb_mode: assert property (@(posedge sysClk) disable iff (!arstN)
      (timerBModeField == 2'h1) |=> timerBPinOe) // RULE12
      else $error("timer B pin not enabled");
   chk_vref_en: assert property (@(posedge sysClk) disable iff (!arstN)
      (!adcStandbyBit && !dac0Enable && !dac1Enable) |=> !vrefInputEn) // RULE16
      else $error("reference input wrongly on");
endmodule
`default_nettype wire

// >>> test/p4pfs_pin_model.sv
// Board-side model of the shared receive pin with its external driver
`timescale 1ns/1ps
`default_nettype none
module p4pfs_pin_model (
   // Device side of the pin
   input wire logic pinOut,
   input wire logic pinOe,
   input wire logic pullupEn,
   // Board driver
   input wire logic boardDrive,
   input wire logic boardLevel,
   // Level seen back by the device
   output logic pinLevel
);
   // Device drive wins, then the board driver; a released pin rests on its pull
   // Board pull-down is weaker than the on-chip pull-up, so an idle pin never floats
   always_comb begin
      if (pinOe) begin
         pinLevel = pinOut;
      end else if (boardDrive) begin
         pinLevel = boardLevel;
      end else begin
         pinLevel = pullupEn;
      end
   end
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the port 4 pin function select block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import p4pfs_pkg::*;
   // Clock and reset
   logic sysClk = 1'b0;
   logic arstN = 1'b0;
   // Control bits; pull-up and pin enable start high so reset has something to hide
   logic p45DirectionBit = 1'b0, p46DirectionBit = 1'b0, p47DirectionBit = 1'b0;
   logic p4HiPullupBit = 1'b1, p4HiDriveBit = 1'b0, p45OutData = 1'b0;
   logic p46OutData = 1'b0, p47OutData = 1'b0, extInt0InputEnable = 1'b0;
   logic uart2I2cModeBit = 1'b0, uart2OpendrainBit = 1'b0, uart2SclOut = 1'b0;
   logic adcStandbyBit = 1'b0, dac0Enable = 1'b0, dac1Enable = 1'b0;
   logic subClockSourceBit = 1'b0, subOscStopBit = 1'b0, subOscPinSelect = 1'b0;
   logic mainOscStopBit = 1'b0, allClockStopBit = 1'b0, mainOscFeedbackOffBit = 1'b0;
   logic subOscFeedbackOffBit = 1'b0, mainOscPinEnable = 1'b1, timerBOutputCtrl = 1'b0;
   logic timerBWave = 1'b1, boardDrive = 1'b0, boardLevel = 1'b0;
   logic [1:0] uart2RxPinSelect = 2'h0, adcTriggerSourceSelect = 2'h0, timerBModeField = 2'h0;
   logic [2:0] uart2SerialModeSelect = 3'h0;
   // Design outputs and pin level
   logic p45PinIn, p45PinOut, p45PinOe, p46PinOut, p46PinOe, p47PinOut, p47PinOe;
   logic p4PullupEn, p4HiDriveEn, externalInterruptZero, uart2ReceiveInput;
   logic adcExternalTrigger, vrefInputEn, mainOscBufOn, mainOscFbOn, subOscBufOn;
   logic subOscFbOn, timerBOutputPin, timerBPinOe;
   p4pfs_tbfn_e timerBFunction;
   // Score
   int nFail = 0;
   int totalChecks = 0;

   // 50 ns period
   always #25 sysClk = ~sysClk;

   p4pfs_port4_pin_select dut_u (.*);
   p4pfs_pin_model model_u (.pinOut(p45PinOut), .pinOe(p45PinOe), .pullupEn(p4PullupEn),
      .boardDrive(boardDrive), .boardLevel(boardLevel), .pinLevel(p45PinIn));

   // Compare of packed level bits
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      totalChecks++;
      if (got !== exp) begin
         nFail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Compare of the timer pin function
   task automatic chkFn(input p4pfs_tbfn_e got, input p4pfs_tbfn_e exp);
      chk({5'h0, got}, {5'h0, exp});
   endtask
   // Outputs answer one edge after inputs change at a falling edge
   task automatic tick;
      @(negedge sysClk);
   endtask
   // Verdict and end of run
   task automatic final_report;
      $display("checks=%0d mismatches=%0d", totalChecks, nFail);
      if (nFail == 0 && totalChecks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Pull-up and drive strength follow their bits
   task automatic t_pull_drive;
      p4HiDriveBit = 1'b1;
      tick;
      chk({6'h0, p4PullupEn, p4HiDriveEn}, 8'h03);
      p4HiPullupBit = 1'b0;
      p4HiDriveBit = 1'b0;
      tick;
      chk({6'h0, p4PullupEn, p4HiDriveEn}, 8'h00);
      $display("test pull_drive done");
   endtask
   // General port, interrupt and trigger routing
   task automatic t_port;
      p45DirectionBit = 1'b1;
      p45OutData = 1'b1;
      tick;
      chk({6'h0, p45PinOe, p45PinOut}, 8'h03);
      p45DirectionBit = 1'b0;
      extInt0InputEnable = 1'b1;
      adcTriggerSourceSelect = 2'h3;
      boardDrive = 1'b1;
      boardLevel = 1'b1;
      tick;
      chk({5'h0, p45PinOe, externalInterruptZero, adcExternalTrigger}, 8'h03);
      adcTriggerSourceSelect = 2'h2;
      tick;
      chk({5'h0, p45PinOe, externalInterruptZero, adcExternalTrigger}, 8'h02);
      extInt0InputEnable = 1'b0;
      $display("test port done");
   endtask
   // Receive pin as UART input, then as I2C clock in both drive styles
   task automatic t_scl;
      uart2RxPinSelect = 2'h3;
      uart2SerialModeSelect = 3'h2;
      tick;
      chk({6'h0, p45PinOe, uart2ReceiveInput}, 8'h01);
      uart2I2cModeBit = 1'b1;
      boardDrive = 1'b0;
      uart2OpendrainBit = 1'b1;
      tick;
      chk({6'h0, p45PinOe, p45PinOut}, 8'h02);
      uart2SclOut = 1'b1;
      tick;
      chk({6'h0, p45PinOe, p45PinOut}, 8'h00);
      uart2OpendrainBit = 1'b0;
      tick;
      chk({6'h0, p45PinOe, p45PinOut}, 8'h03);
      uart2SerialModeSelect = 3'h3;
      tick;
      chk({6'h0, p45PinOe, p45PinOut}, 8'h00);
      uart2RxPinSelect = 2'h0;
      uart2I2cModeBit = 1'b0;
      $display("test scl done");
   endtask
   // Oscillator table: eight clock bits, then expected main/sub buffer and resistor
   task automatic t_osc;
      logic [11:0] row [8] = '{12'h01C, 12'h058, 12'h114, 12'hA13,
                               12'hA32, 12'hE11, 12'hA90, 12'h000};
      p46DirectionBit = 1'b1;
      for (int i = 0; i < 8; i++) begin
         {subClockSourceBit, subOscStopBit, subOscPinSelect, mainOscStopBit, allClockStopBit,
          mainOscFeedbackOffBit, subOscFeedbackOffBit, mainOscPinEnable} = row[i][11:4];
         tick;
         chk({4'h0, mainOscBufOn, mainOscFbOn, subOscBufOn, subOscFbOn},
             {4'h0, row[i][3:0]});
      end
      chk({6'h0, p46PinOe, p47PinOe}, 8'h02);
      $display("test osc done");
   endtask
   // One timer mode setting and its expected pin function
   task automatic tmode(input logic [1:0] m, input logic c, input p4pfs_tbfn_e f);
      timerBModeField = m;
      timerBOutputCtrl = c;
      tick;
      chkFn(timerBFunction, f);
      chk({7'h0, timerBPinOe}, {7'h0, f != P4PFS_TB_OFF});
   endtask
   // All timer pin modes plus the refused mode 11 combination and mode 00
   task automatic t_timer;
      tmode(2'h1, 1'b0, P4PFS_TB_PULSE);
      tmode(2'h1, 1'b1, P4PFS_TB_PROG);
      tmode(2'h2, 1'b0, P4PFS_TB_ONESHOT);
      tmode(2'h3, 1'b0, P4PFS_TB_WAIT);
      tmode(2'h3, 1'b1, P4PFS_TB_OFF);
      tmode(2'h0, 1'b0, P4PFS_TB_OFF);
      $display("test timer done");
   endtask
   // Reference input for every standby and converter enable mix
   task automatic t_vref;
      for (int i = 0; i < 8; i++) begin
         {adcStandbyBit, dac0Enable, dac1Enable} = i[2:0];
         tick;
         chk({7'h0, vrefInputEn}, {7'h0, i != 0});
      end
      $display("test vref done");
   endtask

   // Main sequence: hold reset five cycles, then the scenarios
   initial begin
      repeat (5) @(negedge sysClk);
      chk({p45PinOe, p45PinOut, p4PullupEn, mainOscBufOn, mainOscFbOn, subOscBufOn,
           vrefInputEn, timerBPinOe}, 8'h00);
      chkFn(timerBFunction, P4PFS_TB_OFF);
      arstN = 1'b1;
      tick;
      $display("test reset done");
      t_pull_drive;
      t_port;
      t_scl;
      t_osc;
      t_timer;
      t_vref;
      final_report;
   end
   // Watchdog well beyond the roughly 40 cycles the scenarios need
   initial begin
      repeat (2000) @(posedge sysClk);
      nFail++;
      final_report;
   end
endmodule
`default_nettype wire
